// *** inc/ipsa_params.svh ***
// Purpose: constants of the priority-select block (offsets, fields, resets)
// Assumes: included by its bare name from the top design and testbench files
// Notes: one 32-bit aligned AXI4-Lite word per register
//
// Behaviour
// - eight-bit priority register, read and write
// - reset and hardware standby clear it
// - bit zero low level, one high
// - bit 7 sets external request 0
// - bit 6 sets external request 1
// - bit 5 shared by external requests 2, 3
// - bit 4 shared by external requests 4, 5
// - bit 3 shared by watchdog and converter
// - bit 2 sets timer16 channel 0
// - bit 1 sets timer16 channel 1
// - bit 0 sets timer16 channel 2
// - arbitrate by level, nonmaskable always above
`ifndef IPSA_PARAMS_SVH
`define IPSA_PARAMS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define IPSA_OFF_PRIO_A 8'h00
`define IPSA_OFF_STATUS 8'h04

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define IPSA_PRIO_A_RST 8'h00

// ------------------------------------------------------------
// priority field positions
// ------------------------------------------------------------
`define IPSA_BIT_EXT0 7
`define IPSA_BIT_EXT1 6
`define IPSA_BIT_EXT2_3 5
`define IPSA_BIT_EXT4_5 4
`define IPSA_BIT_WDT_ADC 3
`define IPSA_BIT_T16_CH0 2
`define IPSA_BIT_T16_CH1 1
`define IPSA_BIT_T16_CH2 0

// ------------------------------------------------------------
// status register field positions
// ------------------------------------------------------------
`define IPSA_ST_ID_LSB 0
`define IPSA_ST_LEVEL 4
`define IPSA_ST_NMI 5
`define IPSA_ST_VALID 6

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define IPSA_RESP_OKAY 2'h0
`define IPSA_RESP_SLVERR 2'h2

`endif

// *** inc/ipsa_pkg.sv ***
// Purpose: shared types of the priority-select block
// Assumes: ipsa_params.svh holds the register numbers; source and state codes are set here
// Notes: nothing is imported; users write ipsa_pkg::name
`default_nettype none
package ipsa_pkg;
    // ------------------------------------------------------------
    // maskable source indices, lowest index wins a tie
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SRC_EXT0 = 4'h0,
        SRC_EXT1 = 4'h1,
        SRC_EXT2 = 4'h2,
        SRC_EXT3 = 4'h3,
        SRC_EXT4 = 4'h4,
        SRC_EXT5 = 4'h5,
        SRC_WDT = 4'h6,
        SRC_ADC = 4'h7,
        SRC_T16_CH0 = 4'h8,
        SRC_T16_CH1 = 4'h9,
        SRC_T16_CH2 = 4'hA
    } ipsa_src_t;

    // ------------------------------------------------------------
    // bus channel state machines, one-hot
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WS_IDLE = 2'h1,
        WS_RESP = 2'h2
    } ipsa_wstate_t;

    typedef enum logic [1:0] {
        RS_IDLE = 2'h1,
        RS_DATA = 2'h2
    } ipsa_rstate_t;
endpackage
`default_nettype wire

// *** logic/ipsa_arbiter.sv ***
// Purpose: picks the winning pending request from per-source levels
// Assumes: requests and levels come from logic on the same clock
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module ipsa_arbiter #(
    parameter int NUM_SRC = 11
) (
    input wire logic [NUM_SRC-1:0] req,
    input wire logic [NUM_SRC-1:0] level,
    input wire logic nmi_req,
    output logic win_valid,
    output logic win_nmi,
    output logic win_level,
    output logic [3:0] win_id
);
    // requests that sit at the high level
    logic [NUM_SRC-1:0] req_hi;
    // the set arbitration draws from
    logic [NUM_SRC-1:0] pool;

    // ------------------------------------------------------------
    // split each request by its level
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi = gi + 1)
        begin : g_split
            assign req_hi[gi] = req[gi] & level[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // nonmaskable first, then high level, then lowest index
    // ------------------------------------------------------------
    always_comb
    begin
        pool = (|req_hi) ? req_hi : req;
        win_valid = nmi_req | (|req);
        win_nmi = nmi_req;
        win_level = |req_hi;
        win_id = 4'h0;
        // scan downward so the lowest index is left standing
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (pool[i])
            begin
                win_id = i[3:0];
            end
        end
        // the nonmaskable winner reports no maskable index
        if (nmi_req)
        begin
            win_level = 1'b0;
            win_id = 4'h0;
        end
    end
endmodule
`default_nettype wire

// *** logic/ipsa_top.sv ***
// Purpose: priority-select register with AXI4-Lite access and arbitration
// Assumes: requests come from logic on this clock; standby is a pin
// Notes: clk_en low freezes every flip-flop
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`include "ipsa_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ipsa_top #(
    parameter int ADDR_W = 8,
    parameter int NUM_SRC = 11
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic hw_standby,
    input wire logic [NUM_SRC-1:0] src_req,
    input wire logic nmi_req,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [NUM_SRC-1:0] src_level,
    output logic win_valid,
    output logic win_nmi,
    output logic win_level,
    output logic [3:0] win_id
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic stby_meta_r; // first synchroniser stage
    logic stby_sync_r; // synchronised standby level
    logic [7:0] priority_select_a_reg_r; // the priority register
    logic [7:0] prio_nxt;
    ipsa_pkg::ipsa_wstate_t wst_r, wst_nxt; // write channel state
    logic aw_got_r, aw_got_nxt; // address captured
    logic w_got_r, w_got_nxt; // data captured
    logic [ADDR_W-1:0] waddr_r, waddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic do_write; // both halves present, commit now
    ipsa_pkg::ipsa_rstate_t rst_r, rst_nxt; // read channel state
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [NUM_SRC-1:0] level_map; // per-source level from the register
    logic [NUM_SRC-1:0] level_r;
    logic a_valid, a_nmi, a_level; // arbiter answer
    logic [3:0] a_id;
    logic win_valid_r, win_nmi_r, win_level_r;
    logic [3:0] win_id_r;
    logic [31:0] status_word;

    // ------------------------------------------------------------
    // standby pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stby_meta_r <= 1'b0;
            stby_sync_r <= 1'b0;
        end
        else if (clk_en)
        begin
            stby_meta_r <= hw_standby;
            stby_sync_r <= stby_meta_r;
        end
    end

    // ------------------------------------------------------------
    // write channel: address and data in either order
    // ------------------------------------------------------------
    always_comb
    begin
        wst_nxt = wst_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        awready_nxt = 1'b0;
        wready_nxt = 1'b0;
        do_write = 1'b0;
        case (wst_r)
            ipsa_pkg::WS_IDLE:
            begin
                // capture address half
                if (s_axi_awvalid && awready_r)
                begin
                    aw_got_nxt = 1'b1;
                    waddr_nxt = s_axi_awaddr;
                end
                // capture data half
                if (s_axi_wvalid && wready_r)
                begin
                    w_got_nxt = 1'b1;
                    wdata_nxt = s_axi_wdata;
                    wstrb_nxt = s_axi_wstrb;
                end
                // commit once both are held
                if (aw_got_r && w_got_r)
                begin
                    do_write = 1'b1;
                    aw_got_nxt = 1'b0;
                    w_got_nxt = 1'b0;
                    bvalid_nxt = 1'b1;
                    wst_nxt = ipsa_pkg::WS_RESP;
                    if (waddr_r == `IPSA_OFF_PRIO_A ||
                        waddr_r == `IPSA_OFF_STATUS)
                    begin
                        bresp_nxt = `IPSA_RESP_OKAY;
                    end
                    else
                    begin
                        bresp_nxt = `IPSA_RESP_SLVERR;
                    end
                end
                else
                begin
                    awready_nxt = !aw_got_nxt;
                    wready_nxt = !w_got_nxt;
                end
            end
            ipsa_pkg::WS_RESP:
            begin
                // hold the answer until the master takes it
                if (s_axi_bready)
                begin
                    bvalid_nxt = 1'b0;
                    awready_nxt = 1'b1;
                    wready_nxt = 1'b1;
                    wst_nxt = ipsa_pkg::WS_IDLE;
                end
            end
            default:
            begin
                wst_nxt = ipsa_pkg::WS_IDLE;
                bvalid_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wst_r <= ipsa_pkg::WS_IDLE;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            waddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `IPSA_RESP_OKAY;
        end
        else if (clk_en)
        begin
            wst_r <= wst_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // ------------------------------------------------------------
    // priority register: standby clear beats a write
    // ------------------------------------------------------------
    always_comb
    begin
        prio_nxt = priority_select_a_reg_r;
        if (stby_sync_r)
        begin
            prio_nxt = `IPSA_PRIO_A_RST;
        end
        else if (do_write && waddr_r == `IPSA_OFF_PRIO_A && wstrb_r[0])
        begin
            prio_nxt = wdata_r[7:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            priority_select_a_reg_r <= `IPSA_PRIO_A_RST;
        end
        else if (clk_en)
        begin
            priority_select_a_reg_r <= prio_nxt;
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[`IPSA_ST_ID_LSB +: 4] = win_id_r;
        status_word[`IPSA_ST_LEVEL] = win_level_r;
        status_word[`IPSA_ST_NMI] = win_nmi_r;
        status_word[`IPSA_ST_VALID] = win_valid_r;
        rst_nxt = rst_r;
        arready_nxt = 1'b0;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        case (rst_r)
            ipsa_pkg::RS_IDLE:
            begin
                arready_nxt = 1'b1;
                if (s_axi_arvalid && arready_r)
                begin
                    arready_nxt = 1'b0;
                    rvalid_nxt = 1'b1;
                    rst_nxt = ipsa_pkg::RS_DATA;
                    rresp_nxt = `IPSA_RESP_OKAY;
                    // address decode
                    if (s_axi_araddr == `IPSA_OFF_PRIO_A)
                    begin
                        rdata_nxt = {24'h00_0000, priority_select_a_reg_r};
                    end
                    else if (s_axi_araddr == `IPSA_OFF_STATUS)
                    begin
                        rdata_nxt = status_word;
                    end
                    else
                    begin
                        rdata_nxt = 32'h0000_0000;
                        rresp_nxt = `IPSA_RESP_SLVERR;
                    end
                end
            end
            ipsa_pkg::RS_DATA:
            begin
                // hold data until taken
                if (s_axi_rready)
                begin
                    rvalid_nxt = 1'b0;
                    arready_nxt = 1'b1;
                    rst_nxt = ipsa_pkg::RS_IDLE;
                end
            end
            default:
            begin
                rst_nxt = ipsa_pkg::RS_IDLE;
                rvalid_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_r <= ipsa_pkg::RS_IDLE;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `IPSA_RESP_OKAY;
        end
        else if (clk_en)
        begin
            rst_r <= rst_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ------------------------------------------------------------
    // per-source level map; requests pass through untouched
    // ------------------------------------------------------------
    assign level_map = {
        priority_select_a_reg_r[`IPSA_BIT_T16_CH2],
        priority_select_a_reg_r[`IPSA_BIT_T16_CH1],
        priority_select_a_reg_r[`IPSA_BIT_T16_CH0],
        priority_select_a_reg_r[`IPSA_BIT_WDT_ADC],
        priority_select_a_reg_r[`IPSA_BIT_WDT_ADC],
        priority_select_a_reg_r[`IPSA_BIT_EXT4_5],
        priority_select_a_reg_r[`IPSA_BIT_EXT4_5],
        priority_select_a_reg_r[`IPSA_BIT_EXT2_3],
        priority_select_a_reg_r[`IPSA_BIT_EXT2_3],
        priority_select_a_reg_r[`IPSA_BIT_EXT1],
        priority_select_a_reg_r[`IPSA_BIT_EXT0]
    };

    ipsa_arbiter #(
        .NUM_SRC(NUM_SRC)
    ) u_arb (
        .req(src_req),
        .level(level_map),
        .nmi_req(nmi_req),
        .win_valid(a_valid),
        .win_nmi(a_nmi),
        .win_level(a_level),
        .win_id(a_id)
    );

    // ------------------------------------------------------------
    // registered arbitration outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level_r <= '0;
            win_valid_r <= 1'b0;
            win_nmi_r <= 1'b0;
            win_level_r <= 1'b0;
            win_id_r <= 4'h0;
        end
        else if (clk_en)
        begin
            level_r <= level_map;
            win_valid_r <= a_valid;
            win_nmi_r <= a_nmi;
            win_level_r <= a_level;
            win_id_r <= a_id;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign src_level = level_r;
    assign win_valid = win_valid_r;
    assign win_nmi = win_nmi_r;
    assign win_level = win_level_r;
    assign win_id = win_id_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_commit_prio;
        clk_en && do_write && waddr_r == `IPSA_OFF_PRIO_A && wstrb_r[0]
            && !stby_sync_r;
    endsequence

    a_write_stores: assert property (s_commit_prio |=>
        priority_select_a_reg_r == $past(wdata_r[7:0]))
        else $error("priority write not stored");
    a_standby_clears: assert property (clk_en && stby_sync_r |=>
        priority_select_a_reg_r == 8'h00)
        else $error("standby did not clear priority");
    a_ext0_level: assert property (clk_en |=>
        level_r[0] == $past(priority_select_a_reg_r[7]))
        else $error("external 0 level wrong");
    a_ext1_level: assert property (clk_en |=>
        level_r[1] == $past(priority_select_a_reg_r[6]))
        else $error("external 1 level wrong");
    a_ext23_level: assert property (clk_en |=>
        level_r[2] == level_r[3] && level_r[2] ==
        $past(priority_select_a_reg_r[5]))
        else $error("external 2 and 3 level wrong");
    a_ext45_level: assert property (clk_en |=>
        level_r[5:4] == {2{$past(priority_select_a_reg_r[4])}})
        else $error("external 4 and 5 level wrong");
    a_wdt_adc_level: assert property (clk_en |=>
        level_r[7:6] == {2{$past(priority_select_a_reg_r[3])}})
        else $error("watchdog and converter level wrong");
    a_timer_levels: assert property (clk_en |=>
        level_r[10:8] == {$past(priority_select_a_reg_r[0]),
        $past(priority_select_a_reg_r[1]),
        $past(priority_select_a_reg_r[2])})
        else $error("timer levels wrong");
    a_high_wins: assert property (clk_en && !nmi_req
        && |(src_req & level_map) |=> win_level_r && level_r[win_id_r])
        else $error("high level request lost arbitration");
    a_nmi_on_top: assert property (clk_en && nmi_req |=>
        win_nmi_r && win_valid_r && !win_level_r)
        else $error("nonmaskable request not on top");
    a_pending_kept: assert property (clk_en && !nmi_req |=>
        win_valid_r == $past(|src_req))
        else $error("level changed pending status");
    a_bresp_follows: assert property (clk_en && do_write |=>
        s_axi_bvalid)
        else $error("write answer missing");
endmodule
`default_nettype wire

// *** testbench/ipsa_src_model.sv ***
// Purpose: request sources on the far side of the priority arbiter
// Assumes: sources hold level requests on the core clock
// Notes: requests change only just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ipsa_src_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [10:0] want_req,
    input wire logic want_nmi,
    output logic [10:0] src_req,
    output logic nmi_req
);
    // ------------------------------------------------------------
    // request registers
    // ------------------------------------------------------------
    logic [10:0] req_r; // pending maskable requests
    logic nmi_r; // pending nonmaskable request
    logic [10:0] req_nxt;
    logic nmi_nxt;

    // next values follow what the scenario asks for
    always_comb
    begin
        req_nxt = want_req;
        nmi_nxt = want_nmi;
    end

    // launched after the edge, dropped by reset
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_r <= 11'h000;
            nmi_r <= 1'h0;
        end
        else
        begin
            req_r <= req_nxt;
            nmi_r <= nmi_nxt;
        end
    end

    assign src_req = req_r;
    assign nmi_req = nmi_r;
endmodule
`default_nettype wire

// *** testbench/ipsa_top_test.sv ***
// Purpose: self-checking bench for the priority-select block
// Assumes: bus slave answers whenever it likes; waits are bounded
// Notes: clk_en drops only between bus transfers, to check the freeze
`include "ipsa_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ipsa_top_test;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic hw_standby = 1'h0;
    logic clk_en = 1'h1;
    logic [10:0] want_req = 11'h000;
    logic want_nmi = 1'h0;
    logic [10:0] src_req, src_level;
    logic nmi_req, win_valid, win_nmi, win_level;
    logic [3:0] win_id;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] data;
    int n_errors = 0;
    int comparisons = 0;

    // compare one value, count it, report a miss
    `define CHK(what, exp, got) begin comparisons++; \
        if ((got) !== (exp)) begin n_errors++; \
        $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end end

    always #5 clock = ~clock;

    ipsa_src_model u_src (.clock(clock), .rst_n(rst_n),
        .want_req(want_req), .want_nmi(want_nmi),
        .src_req(src_req), .nmi_req(nmi_req));

    ipsa_top u_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .hw_standby(hw_standby), .src_req(src_req), .nmi_req(nmi_req),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .src_level(src_level), .win_valid(win_valid), .win_nmi(win_nmi),
        .win_level(win_level), .win_id(win_id));

    // ------------------------------------------------------------
    // verdict and bus tasks
    // ------------------------------------------------------------
    task automatic close_out();
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one write; each channel dropped at the edge that takes it
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        logic aw_hs, w_hs, b_hs;
        @(posedge clock);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (i = 0; i < 50; i++)
        begin
            #1;
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid;
            resp = bresp;
            @(posedge clock);
            if (aw_hs) awvalid <= 1'h0;
            if (w_hs) wvalid <= 1'h0;
            if (b_hs)
            begin
                bready <= 1'h0;
                break;
            end
        end
        if (i == 50)
        begin
            n_errors++;
            close_out();
        end
    endtask

    // one read; data and response taken with rvalid
    task automatic bus_rd(input logic [7:0] a);
        int i;
        logic ar_hs, r_hs;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (i = 0; i < 50; i++)
        begin
            #1;
            ar_hs = arvalid && arready;
            r_hs = rvalid;
            data = rdata;
            resp = rresp;
            @(posedge clock);
            if (ar_hs) arvalid <= 1'h0;
            if (r_hs)
            begin
                rready <= 1'h0;
                break;
            end
        end
        if (i == 50)
        begin
            n_errors++;
            close_out();
        end
    endtask

    // wait for levels and winner to settle after a change
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_read_write();
        bus_rd(`IPSA_OFF_PRIO_A);
        `CHK("reset value", 32'h0, data)
        bus_wr(`IPSA_OFF_PRIO_A, 32'hFFFF_FFA5);
        `CHK("wr okay", `IPSA_RESP_OKAY, resp)
        bus_rd(`IPSA_OFF_PRIO_A);
        `CHK("read back", 32'h0000_00A5, data)
        `CHK("read resp", `IPSA_RESP_OKAY, resp)
    endtask

    // every bit alone, all sources pending: map and winner
    task automatic t_bit_map();
        logic [10:0] lv;
        logic [7:0] r;
        int b, k, w;
        want_req <= 11'h7FF;
        for (b = 0; b < 8; b++)
        begin
            r = 8'h01 << b;
            lv = {r[0], r[1], r[2], r[3], r[3], r[4], r[4], r[5], r[5],
                r[6], r[7]};
            w = 0;
            for (k = 10; k >= 0; k--)
                if (lv[k]) w = k;
            bus_wr(`IPSA_OFF_PRIO_A, {24'h0, r});
            settle();
            `CHK("levels", lv, src_level)
            `CHK("winner", 4'(w), win_id)
            `CHK("win level", 1'h1, win_level)
        end
        bus_wr(`IPSA_OFF_PRIO_A, 32'h0);
        settle();
        `CHK("still pending", 1'h1, win_valid)
        `CHK("low winner", 4'h0, win_id)
        `CHK("low level", 1'h0, win_level)
        want_nmi <= 1'h1;
        settle();
        `CHK("nmi wins", 1'h1, win_nmi)
        bus_rd(`IPSA_OFF_STATUS);
        `CHK("status", (32'h1 << `IPSA_ST_VALID) | (32'h1 << `IPSA_ST_NMI),
            data)
        want_nmi <= 1'h0;
        want_req <= 11'h000;
    endtask

    task automatic t_unmapped();
        bus_wr(8'h08, 32'h0000_00FF);
        `CHK("wr resp", `IPSA_RESP_SLVERR, resp)
        bus_rd(8'h08);
        `CHK("rd resp", `IPSA_RESP_SLVERR, resp)
        bus_rd(`IPSA_OFF_PRIO_A);
        `CHK("untouched", 32'h0, data)
    endtask

    // clk_en low holds win_nmi where it stood
    task automatic t_freeze();
        clk_en <= 1'h0;
        want_nmi <= 1'h1;
        settle();
        `CHK("frozen", 1'h0, win_nmi)
        clk_en <= 1'h1;
        settle();
        `CHK("thawed", 1'h1, win_nmi)
        want_nmi <= 1'h0;
        settle();
    endtask

    task automatic t_standby();
        bus_wr(`IPSA_OFF_PRIO_A, 32'h0000_003C);
        bus_rd(`IPSA_OFF_PRIO_A);
        `CHK("before standby", 32'h0000_003C, data)
        hw_standby <= 1'h1;
        repeat (5) @(posedge clock);
        hw_standby <= 1'h0;
        repeat (3) @(posedge clock);
        bus_rd(`IPSA_OFF_PRIO_A);
        `CHK("standby clear", 32'h0, data)
        `CHK("levels cleared", 11'h000, src_level)
    endtask

    // reset for two cycles, then every scenario in turn
    initial
    begin
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        repeat (2) @(posedge clock);
        t_read_write();
        t_bit_map();
        t_unmapped();
        t_freeze();
        t_standby();
        close_out();
    end
endmodule
`default_nettype wire
